//--- svf_deserializer.sv
// Deserializer end: word recovery, error counters and register file
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// How it works
// - Sixteen-bit parity threshold, two bytes, default 16
// - Sixteen-bit video parity error counter, two bytes
// - Eight-bit PRBS bit error count, reset zero
// - Five link error flags, top bits zero
// - Word holds video bits plus both syncs
// - Length is width, two encode, plus two parity when on
// - Bits travel least significant first
// - Plain order: encode, encode, hsync, vsync, data
// - Plain widths 18 to 10 give 20 to 12
// - Parity order: parity, companion, encode, syncs, data
// - Parity widths 16 to 10; none at 18
// - Bit clock is pixel rate times length
// - Width, parity and rates set at startup
// - Controller retunes both ends in one session
// - Reads clear counts unless auto reset set
module svf_deserializer
  import svf_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  svf_link_if.des         link,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic [7:0]      reg_rdata_out,
  input  wire logic [4:0] link_err_in,
  output svf_data_t       video_out,
  output logic            hsync_out,
  output logic            vsync_out,
  output logic            pixel_valid_out,
  output logic            irq_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cfg;
    logic        auto_error_reset;
    logic [15:0] thr;
    logic [15:0] perr;
    logic [7:0]  perr_hi;
    logic [7:0]  prbs_cnt;
    logic [4:0]  flags;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [7:0]  rdata;
    logic [4:0]  cnt;
    svf_word_t   sh;
    logic        done;
    logic [6:0]  hist;
    logic [2:0]  fill;
    svf_data_t   video;
    logic        hs;
    logic        vs;
    logic        pvalid;
  } svf_des_st_t;

  svf_des_st_t s_q;
  svf_des_st_t s_d;

  assign reg_rdata_out   = s_q.rdata;
  assign video_out       = s_q.video;
  assign hsync_out       = s_q.hs;
  assign vsync_out       = s_q.vs;
  assign pixel_valid_out = s_q.pvalid;
  assign irq_out         = |(s_q.stat & s_q.mask);

  // ----------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rd_mux(input svf_des_st_t s,
                                        input logic [7:0]  a);
    case (a)
      SVF_OFS_CONFIG:   return s.cfg;
      SVF_OFS_ERR_CTRL: return {7'h00, s.auto_error_reset};
      SVF_OFS_THR_LO:   return s.thr[7:0];
      SVF_OFS_THR_HI:   return s.thr[15:8];
      SVF_OFS_PERR_LO:  return s.perr[7:0];
      SVF_OFS_PERR_HI:  return s.perr_hi;
      SVF_OFS_PRBS_ERR: return s.prbs_cnt;
      SVF_OFS_FLAGS:    return {3'h0, s.flags};
      SVF_OFS_IRQ_STAT: return {4'h0, s.stat};
      SVF_OFS_IRQ_MASK: return {4'h0, s.mask};
      default:          return 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] sel;
    logic       pon;
    logic       prbs;
    logic [4:0] len;
    svf_data_t  d;
    logic       hs;
    logic       vs;
    logic       frame_err;
    logic       par_err;
    logic       inc;
    logic       prbs_err;
    logic       rd_clr;
    logic [15:0] perr_nx;
    logic [3:0] ev;
    logic [3:0] clr;
    s_d      = s_q;
    inc      = 1'b0;
    perr_nx  = s_q.perr;
    ev       = 4'h0;
    sel      = s_q.cfg[2:0];
    prbs     = s_q.cfg[SVF_CFG_PRBS];
    pon      = svf_par_on(sel, s_q.cfg[SVF_CFG_PAR]);
    len      = svf_word_len(sel, s_q.cfg[SVF_CFG_PAR]);
    d        = '0;
    hs       = 1'b0;
    vs       = 1'b0;
    frame_err = 1'b0;
    par_err  = 1'b0;
    prbs_err = 1'b0;
    rd_clr   = reg_rd_in & ~s_q.auto_error_reset;
    clr      = 4'h0;
    s_d.done   = 1'b0;
    s_d.pvalid = 1'b0;
    s_d.rdata  = 8'h00;

    // Collect bits, first bit at position zero
    if (link.word_start) begin
      s_d.sh  = {19'h0, link.serial_bit};
      s_d.cnt = 5'h01;
    end else if (s_q.cnt != 5'h00) begin
      s_d.sh[s_q.cnt] = link.serial_bit;
      s_d.cnt = s_q.cnt + 5'h01;
    end
    if ((link.word_start || s_q.cnt != 5'h00) && s_d.cnt == len) begin
      s_d.cnt  = 5'h00;
      s_d.done = 1'b1;
    end

    // Decode a finished word
    if (pon) begin
      hs = s_q.sh[4];
      vs = s_q.sh[5];
      d  = {2'h0, s_q.sh[19:6]} & svf_data_mask(sel);
      frame_err = (s_q.sh[2] != SVF_ENC0) || (s_q.sh[3] != SVF_ENC1);
      par_err = (s_q.sh[0] != ^{hs, vs, d}) ||
                (s_q.sh[1] == s_q.sh[0]);
    end else begin
      hs = s_q.sh[2];
      vs = s_q.sh[3];
      d  = s_q.sh[19:4] & svf_data_mask(sel);
      frame_err = (s_q.sh[0] != SVF_ENC0) || (s_q.sh[1] != SVF_ENC1);
    end
    if (s_q.done && !prbs) begin
      s_d.video  = d;
      s_d.hs     = hs;
      s_d.vs     = vs;
      s_d.pvalid = 1'b1;
    end
    frame_err = frame_err & s_q.done & ~prbs;
    inc       = par_err & s_q.done & ~prbs;

    // PRBS7 self-synchronising check on every received bit
    if (!prbs) begin
      s_d.fill = 3'h0;
    end else if (link.word_start || s_q.cnt != 5'h00) begin
      prbs_err = (s_q.fill == SVF_PRBS_FILL) &&
                 (link.serial_bit != (s_q.hist[6] ^ s_q.hist[5]));
      s_d.hist = {s_q.hist[5:0], link.serial_bit};
      if (s_q.fill != SVF_PRBS_FILL) begin
        s_d.fill = s_q.fill + 3'h1;
      end
    end

    // Parity error counter; an error in the clearing cycle is kept
    perr_nx = s_q.perr;
    if (rd_clr && reg_addr_in == SVF_OFS_PERR_LO) begin
      perr_nx = 16'h0000;
    end
    if (reg_rd_in && reg_addr_in == SVF_OFS_PERR_LO) begin
      s_d.perr_hi = s_q.perr[15:8];
    end
    if (inc && perr_nx != 16'hffff) begin
      perr_nx = perr_nx + 16'h0001;
    end
    s_d.perr = perr_nx;

    if (rd_clr && reg_addr_in == SVF_OFS_PRBS_ERR) begin
      s_d.prbs_cnt = {7'h00, prbs_err};
    end else if (prbs_err && s_q.prbs_cnt != 8'hff) begin
      s_d.prbs_cnt = s_q.prbs_cnt + 8'h01;
    end

    if (rd_clr && reg_addr_in == SVF_OFS_FLAGS) begin
      s_d.flags = link_err_in;
    end else begin
      s_d.flags = s_q.flags | link_err_in;
    end

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        SVF_OFS_CONFIG:   s_d.cfg = reg_wdata_in;
        SVF_OFS_ERR_CTRL: s_d.auto_error_reset = reg_wdata_in[0];
        SVF_OFS_THR_LO:   s_d.thr[7:0] = reg_wdata_in;
        SVF_OFS_THR_HI:   s_d.thr[15:8] = reg_wdata_in;
        SVF_OFS_IRQ_STAT: clr = reg_wdata_in[3:0];
        SVF_OFS_IRQ_MASK: s_d.mask = reg_wdata_in[3:0];
        default:          s_d.mask = s_q.mask;
      endcase
    end
    if (reg_rd_in) begin
      s_d.rdata = rd_mux(s_q, reg_addr_in);
    end

    // Sticky events; a new event outranks the write-one clear
    ev[SVF_IRQ_PARITY] = inc;
    ev[SVF_IRQ_FRAME]  = frame_err;
    ev[SVF_IRQ_THRESH] = inc && (perr_nx == s_q.thr);
    ev[SVF_IRQ_PRBS]   = prbs_err;
    s_d.stat = (s_q.stat & ~clr) | ev;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q     <= '0;
      s_q.cfg <= SVF_RST_CONFIG;
      s_q.thr <= {SVF_RST_THR_HI, SVF_RST_THR_LO};
      s_q.hist <= SVF_PRBS_SEED;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- svf_link_asserts.sv
// Framing checks on the serial link between the two framer ends
`timescale 1ns/1ps
module svf_link_asserts
  import svf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic serial_bit,
  input wire logic word_start,
  input wire logic frame_chk_in
);
  // ----
  // Word tracking
  // ----
  logic [4:0] cnt_q;
  logic       first_q;
  logic       xor_q;
  logic       seen_q;

  // Saturates so a stuck link cannot wrap back into a legal length
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q   <= 5'h00;
      first_q <= 1'b1;
      xor_q   <= 1'b0;
      seen_q  <= 1'b0;
    end else if (word_start) begin
      cnt_q   <= 5'h01;
      first_q <= serial_bit;
      xor_q   <= serial_bit;
      seen_q  <= 1'b1;
    end else begin
      cnt_q   <= (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
      xor_q   <= xor_q ^ serial_bit;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  // Framing rules do not hold while the test pattern fills the words
  default disable iff (!rst_b_in || !frame_chk_in);

  // ----
  // Properties
  // ----
  a_len_legal: assert property (word_start && seen_q |->
    cnt_q inside {5'h0c, 5'h0e, 5'h10, 5'h12, 5'h14})
    else $error("serial word length not legal");
  a_len_bound: assert property (seen_q && !word_start |->
    cnt_q < 5'h14) else $error("serial word longer than twenty bits");
  a_par_len: assert property (word_start && seen_q && !first_q |->
    cnt_q != 5'h0c) else $error("parity word of twelve bits");
  a_par_even: assert property (word_start && seen_q && !first_q |->
    !xor_q) else $error("parity bit does not match word");
  a_pair_compl: assert property (word_start |=>
    serial_bit != $past(serial_bit)) else $error("second bit not inverse");
  a_enc_after_par: assert property (word_start && !serial_bit |->
    ##2 serial_bit == SVF_ENC0 ##1 serial_bit == SVF_ENC1)
    else $error("encode bits misplaced after parity pair");
  a_start_pulse: assert property (word_start |=> !word_start [*8])
    else $error("word start repeats too soon");
  a_first_word: assert property ($rose(rst_b_in) |=> word_start)
    else $error("first word late after reset");
endmodule

//--- svf_link_if.sv
// Serial link between serializer and deserializer, one bit per clock
`timescale 1ns/1ps
interface svf_link_if;
  logic serial_bit;
  logic word_start;

  modport ser (output serial_bit, output word_start);
  modport des (input serial_bit, input word_start);
endinterface

//--- svf_pkg.sv
// Shared constants, types and word helpers for the serial video word framer
package svf_pkg;

  // ----------------------------------------------------------------------
  // Word geometry
  // ----------------------------------------------------------------------
  localparam int unsigned SVF_WORD_MAX = 20;
  localparam int unsigned SVF_DATA_MAX = 16;
  typedef logic [SVF_WORD_MAX-1:0] svf_word_t;
  typedef logic [SVF_DATA_MAX-1:0] svf_data_t;

  // Parallel width select codes; any code with bit 2 set means 18
  localparam logic [2:0] SVF_PW_10 = 3'h0;
  localparam logic [2:0] SVF_PW_12 = 3'h1;
  localparam logic [2:0] SVF_PW_14 = 3'h2;
  localparam logic [2:0] SVF_PW_16 = 3'h3;
  localparam logic [2:0] SVF_PW_18 = 3'h5;

  localparam logic [4:0] SVF_PW_BASE  = 5'h0a;
  localparam logic [4:0] SVF_PW_WIDE  = 5'h12;
  localparam logic [4:0] SVF_ENC_BITS = 5'h02;
  localparam logic [4:0] SVF_PAR_BITS = 5'h02;

  // Encoding bit values, identical on both ends
  localparam logic SVF_ENC0 = 1'b1;
  localparam logic SVF_ENC1 = 1'b0;

  // PRBS7 history length before errors are counted
  localparam logic [2:0] SVF_PRBS_FILL = 3'h7;
  localparam logic [6:0] SVF_PRBS_SEED = 7'h7f;

  // ----------------------------------------------------------------------
  // Deserializer register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] SVF_OFS_CONFIG   = 8'h00;
  localparam logic [7:0] SVF_OFS_ERR_CTRL = 8'h01;
  localparam logic [7:0] SVF_OFS_THR_LO   = 8'h08;
  localparam logic [7:0] SVF_OFS_THR_HI   = 8'h09;
  localparam logic [7:0] SVF_OFS_PERR_LO  = 8'h0a;
  localparam logic [7:0] SVF_OFS_PERR_HI  = 8'h0b;
  localparam logic [7:0] SVF_OFS_PRBS_ERR = 8'h0c;
  localparam logic [7:0] SVF_OFS_FLAGS    = 8'h0d;
  localparam logic [7:0] SVF_OFS_IRQ_STAT = 8'h0e;
  localparam logic [7:0] SVF_OFS_IRQ_MASK = 8'h0f;

  localparam logic [7:0] SVF_RST_CONFIG = 8'h05;
  localparam logic [7:0] SVF_RST_THR_LO = 8'h10;
  localparam logic [7:0] SVF_RST_THR_HI = 8'h00;

  // Config field positions
  localparam int unsigned SVF_CFG_PAR  = 3;
  localparam int unsigned SVF_CFG_PRBS = 4;

  // Interrupt status bits
  localparam int unsigned SVF_IRQ_PARITY = 0;
  localparam int unsigned SVF_IRQ_FRAME  = 1;
  localparam int unsigned SVF_IRQ_THRESH = 2;
  localparam int unsigned SVF_IRQ_PRBS   = 3;

  // ----------------------------------------------------------------------
  // Word helpers
  // ----------------------------------------------------------------------
  function automatic logic [4:0] svf_par_width(input logic [2:0] sel);
    return sel[2] ? SVF_PW_WIDE : SVF_PW_BASE + {2'h0, sel[1:0], 1'b0};
  endfunction

  // No parity format exists for the 18-bit width
  function automatic logic svf_par_on(input logic [2:0] sel,
                                      input logic       pen);
    return pen & ~sel[2];
  endfunction

  function automatic logic [4:0] svf_word_len(input logic [2:0] sel,
                                              input logic       pen);
    return svf_par_width(sel) + SVF_ENC_BITS +
           (svf_par_on(sel, pen) ? SVF_PAR_BITS : 5'h00);
  endfunction

  function automatic svf_data_t svf_data_mask(input logic [2:0] sel);
    case (sel)
      SVF_PW_10: return 16'h00ff;
      SVF_PW_12: return 16'h03ff;
      SVF_PW_14: return 16'h0fff;
      SVF_PW_16: return 16'h3fff;
      default:   return 16'hffff;
    endcase
  endfunction

  function automatic svf_word_t svf_build(input logic [2:0] sel,
                                          input logic       pen,
                                          input logic       hs,
                                          input logic       vs,
                                          input svf_data_t  data);
    svf_data_t d;
    logic      p;
    d = data & svf_data_mask(sel);
    p = ^{hs, vs, d};
    if (svf_par_on(sel, pen)) begin
      return {d[13:0], vs, hs, SVF_ENC1, SVF_ENC0, ~p, p};
    end
    return {d, vs, hs, SVF_ENC1, SVF_ENC0};
  endfunction

endpackage

//--- svf_serializer.sv
// Serializer end: frames pixels into serial words, LSB first
`timescale 1ns/1ps
module svf_serializer
  import svf_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  svf_link_if.ser         link,
  input  wire logic       cfg_load_in,
  input  wire logic [2:0] cfg_width_in,
  input  wire logic       cfg_parity_in,
  input  wire logic       cfg_prbs_in,
  input  wire logic       hsync_in,
  input  wire logic       vsync_in,
  input  wire svf_data_t  video_in,
  output logic            pixel_take_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] cnt;
    logic [4:0] len;
    logic [2:0] sel;
    logic       pen;
    logic       prbs;
    logic [2:0] new_sel;
    logic       new_pen;
    logic       new_prbs;
    svf_word_t  sh;
    logic       bit_out;
    logic       start;
    logic [6:0] lfsr;
  } svf_ser_st_t;

  svf_ser_st_t s_q;
  svf_ser_st_t s_d;

  // Pixel rate is the bit rate divided by the word length
  assign pixel_take_out  = (s_q.cnt == 5'h00);
  assign link.serial_bit = s_q.bit_out;
  assign link.word_start = s_q.start;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    svf_word_t w;
    logic      fb;
    s_d = s_q;
    w   = '0;
    fb  = s_q.lfsr[6] ^ s_q.lfsr[5];
    s_d.start = 1'b0;
    // Startup configuration held until the next word boundary
    if (cfg_load_in) begin
      s_d.new_sel  = cfg_width_in;
      s_d.new_pen  = cfg_parity_in;
      s_d.new_prbs = cfg_prbs_in;
    end
    if (s_q.cnt == 5'h00) begin
      s_d.sel   = s_q.new_sel;
      s_d.pen   = s_q.new_pen;
      s_d.prbs  = s_q.new_prbs;
      s_d.len   = svf_word_len(s_q.new_sel, s_q.new_pen);
      w = svf_build(s_q.new_sel, s_q.new_pen, hsync_in, vsync_in,
                    video_in);
      s_d.bit_out = w[0];
      s_d.sh    = w >> 1;
      s_d.start = 1'b1;
    end else begin
      s_d.bit_out = s_q.sh[0];
      s_d.sh      = s_q.sh >> 1;
    end
    // Test pattern replaces every word bit but keeps word timing
    if (s_d.prbs) begin
      s_d.bit_out = fb;
      s_d.lfsr    = {s_q.lfsr[5:0], fb};
    end
    if (s_q.cnt == 5'h00) begin
      s_d.cnt = (s_d.len == 5'h01) ? 5'h00 : 5'h01;
    end else if (s_q.cnt == s_q.len - 5'h01) begin
      s_d.cnt = 5'h00;
    end else begin
      s_d.cnt = s_q.cnt + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q          <= '0;
      s_q.sel      <= SVF_PW_18;
      s_q.new_sel  <= SVF_PW_18;
      s_q.len      <= 5'h14;
      s_q.lfsr     <= SVF_PRBS_SEED;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- test_serial_video_word_framer.sv
// Serializer and deserializer joined over the link, driven from user sides
`timescale 1ns/1ps
module test_serial_video_word_framer
  import svf_pkg::*;
  ;
  logic       sys_clk_in, rst_b_in, cfg_load_in, cfg_parity_in;
  logic       cfg_prbs_in, frame_chk;
  logic       hsync_in, vsync_in, hsync_out, vsync_out, irq_out;
  logic       reg_wr_in, reg_rd_in, pixel_valid_out, pixel_take_out;
  logic [2:0] cfg_width_in;
  logic [4:0] link_err_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd_q;
  svf_data_t  video_in, video_out;
  svf_word_t  cur_w, last_w;
  int         num_errors = 0, n_tests = 0, cyc = 0, cur_n = 0, last_n = 0;
  int         tk_n = 0, tk_last = 0;
  logic [7:0] r_adr [11] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0a, 8'h0b,
                             8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h20};
  logic [7:0] r_exp [11] = '{8'h05, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [2:0] m_sel [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5,
                             3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  logic       m_par [10] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1};

  svf_link_if svf_link_if_inst ();
  svf_serializer svf_serializer_inst (.sys_clk_in, .rst_b_in,
    .link(svf_link_if_inst), .cfg_load_in, .cfg_width_in, .cfg_parity_in,
    .cfg_prbs_in, .hsync_in, .vsync_in, .video_in, .pixel_take_out);
  svf_deserializer svf_deserializer_inst (.sys_clk_in, .rst_b_in,
    .link(svf_link_if_inst), .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .link_err_in, .video_out, .hsync_out,
    .vsync_out, .pixel_valid_out, .irq_out);
  svf_link_asserts svf_link_asserts_inst (.sys_clk_in, .rst_b_in,
    .serial_bit(svf_link_if_inst.serial_bit),
    .word_start(svf_link_if_inst.word_start), .frame_chk_in(frame_chk));

  // ----
  // Clock, wire capture, timeout
  // ----
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Keeps the last complete word seen on the wire, LSB first
  always @(posedge sys_clk_in) begin
    if (svf_link_if_inst.word_start === 1'b1) begin
      last_w = cur_w;
      last_n = cur_n;
      cur_w = '0;
      cur_n = 0;
    end
    if (cur_n < 20) cur_w[cur_n] = svf_link_if_inst.serial_bit;
    cur_n++;
    // Pixel pickup period, which must equal the word length
    if (pixel_take_out === 1'b1) begin
      tk_last = tk_n;
      tk_n = 0;
    end
    tk_n++;
  end

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    rd_q = reg_rdata_out;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    reg_rd(a);
    chk(20'(rd_q), 20'(e));
  endtask

  // Both ends get the same mode; the wire settles at the next word
  task automatic setup(input logic [2:0] s, input logic p, h, v,
                       input svf_data_t d);
    @(posedge sys_clk_in);
    cfg_width_in <= s;
    cfg_parity_in <= p;
    cfg_load_in <= 1'b1;
    hsync_in <= h;
    vsync_in <= v;
    video_in <= d;
    @(posedge sys_clk_in);
    cfg_load_in <= 1'b0;
    reg_wr(8'h00, {4'h0, p, s});
  endtask

  task automatic wait_starts(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge sys_clk_in);
        k++;
      end while (svf_link_if_inst.word_start !== 1'b1 && k < 40);
    end
  endtask

  function automatic svf_word_t exp_word(input int nd, input logic pe, h,
                                          v, input svf_data_t d);
    svf_data_t dm;
    svf_word_t w;
    logic      p;
    dm = d & (16'hffff >> (16 - nd));
    p = ^{h, v, dm};
    w = {dm, v, h, SVF_ENC1, SVF_ENC0};
    if (pe) w = {w[17:0], ~p, p};
    return w;
  endfunction

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    logic [2:0] s;
    logic       pe;
    int         nd, k;
    svf_data_t  d;
    {rst_b_in, cfg_load_in, cfg_width_in, cfg_parity_in} = '0;
    {hsync_in, vsync_in, video_in, link_err_in, cfg_prbs_in} = '0;
    frame_chk = 1'b1;
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
    repeat (20) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 11; i++) rchk(r_adr[i], r_exp[i]);
    reg_wr(8'h08, 8'h03);
    rchk(8'h08, 8'h03);
    reg_wr(8'h09, 8'ha5);
    rchk(8'h09, 8'ha5);
    reg_wr(8'h09, 8'h00);
    reg_wr(8'h0a, 8'hff);
    rchk(8'h0a, 8'h00);
    @(posedge sys_clk_in);
    link_err_in <= 5'h1f;
    repeat (2) @(posedge sys_clk_in);
    link_err_in <= 5'h00;
    rchk(8'h0d, 8'h1f);
    rchk(8'h0d, 8'h00);
    reg_wr(8'h01, 8'h01);
    link_err_in <= 5'h04;
    repeat (2) @(posedge sys_clk_in);
    link_err_in <= 5'h00;
    rchk(8'h0d, 8'h04);
    rchk(8'h0d, 8'h04);
    reg_wr(8'h01, 8'h00);
    for (int i = 0; i < 10; i++) begin
      s = m_sel[i];
      pe = m_par[i] & ~s[2];
      nd = s[2] ? 16 : 8 + 2 * s[1:0];
      d = 16'hb5e7 ^ {4{4'(i)}};
      setup(s, m_par[i], i[0], i[1], d);
      wait_starts(4);
      k = 0;
      do begin
        @(negedge sys_clk_in);
        k++;
      end while (pixel_valid_out !== 1'b1 && k < 40);
      chk(20'(last_n), 20'(nd + 4 + 2 * pe));
      chk(20'(tk_last), 20'(nd + 4 + 2 * pe));
      chk(last_w, exp_word(nd, pe, i[0], i[1], d));
      chk({2'h0, hsync_out, vsync_out, video_out},
          {2'h0, i[0], i[1], d & (16'hffff >> (16 - nd))});
    end
    // Ends disagree on parity at equal length: every word fails parity
    setup(3'h2, 1'b0, 1'b1, 1'b0, 16'h0000);
    reg_wr(8'h00, 8'h09);
    wait_starts(4);
    reg_rd(8'h0a);
    reg_wr(8'h0e, 8'h0f);
    wait_starts(8);
    chk(20'(irq_out), 20'h0);
    rchk(8'h0e, 8'h05);
    reg_wr(8'h0f, 8'h01);
    @(negedge sys_clk_in);
    chk(20'(irq_out), 20'h1);
    setup(3'h1, 1'b1, 1'b1, 1'b0, 16'h0000);
    wait_starts(4);
    reg_wr(8'h0e, 8'h0f);
    reg_rd(8'h0a);
    rchk(8'h0b, 8'h00);
    rchk(8'h0a, 8'h00);
    rchk(8'h0e, 8'h00);
    chk(20'(irq_out), 20'h0);
    // Test pattern on both ends, framing checks paused meanwhile
    @(posedge sys_clk_in);
    frame_chk <= 1'b0;
    cfg_prbs_in <= 1'b1;
    cfg_load_in <= 1'b1;
    @(posedge sys_clk_in);
    cfg_load_in <= 1'b0;
    wait_starts(2);
    reg_wr(8'h00, 8'h19);
    wait_starts(2);
    reg_rd(8'h0c);
    reg_wr(8'h0e, 8'h0f);
    wait_starts(4);
    rchk(8'h0c, 8'h00);
    rchk(8'h0e, 8'h00);
    // Far end back on video while this end still checks the pattern
    @(posedge sys_clk_in);
    cfg_prbs_in <= 1'b0;
    cfg_load_in <= 1'b1;
    @(posedge sys_clk_in);
    cfg_load_in <= 1'b0;
    wait_starts(4);
    rchk(8'h0e, 8'h08);
    reg_rd(8'h0c);
    chk(20'(rd_q == 8'h00), 20'h0);
    reg_wr(8'h00, 8'h09);
    wait_starts(2);
    @(posedge sys_clk_in);
    frame_chk <= 1'b1;
    wait_starts(2);
    finish_test();
  end
endmodule
